// ---- hw/ovsc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ovsc_regs.svh"
module ovsc_top #(
  parameter int STEP_CYC    = `OVSC_STEP_CYC,
  parameter int TIMEOUT_CYC = `OVSC_TIMEOUT_CYC,
  parameter int SETTLE_CYC  = `OVSC_SETTLE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        enable_pin,
  input  wire logic        switch_cycle,
  input  wire logic        fault_raw,
  input  wire logic        gate_request,
  input  wire logic        switch_node_high,
  output var  logic [7:0]  reference_code,
  output var  logic        fault_report,
  output var  logic        light_load_save,
  output var  logic        ultrasonic_save,
  output var  logic        slew_discharge_on,
  output var  logic        soft_shutdown_on,
  output var  logic        high_side_gate_drive,
  output var  logic        high_side_strong,
  output var  logic        irq
);
  import ovsc_pkg::*;

  localparam int SW = $clog2(STEP_CYC + 1);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int CW = $clog2(SETTLE_CYC + 1);

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  ovsc_ctrl_type   ctrl;
  ovsc_target_type target;
  ovsc_event_type  irq_status;
  ovsc_event_type  irq_mask;
  ovsc_event_type  events;
  ovsc_state_type  state;
  logic            aw_held;
  logic            w_held;
  logic [7:0]      aw_addr_q;
  logic [31:0]     w_data_q;
  logic [3:0]      w_strb_q;
  logic [7:0]      ref_q;
  logic            dir_down;
  logic            en_seen;

  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire ar_take  = arvalid & arready;
  wire wr_do    = aw_held & w_held & ~bvalid;
  wire next_aw_held = (aw_held | aw_take) & ~wr_do;
  wire next_w_held  = (w_held | w_take) & ~wr_do;
  wire next_bvalid  = wr_do | (bvalid & ~bready);
  wire next_rvalid  = ar_take | (rvalid & ~rready);
  wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
  wire [7:0] ra = {araddr[7:2], 2'b00};
  wire wlo      = wr_do & w_strb_q[0];
  wire wr_ctrl  = wlo & (wa == `OVSC_CTRL_OFF);
  wire wr_targ  = wlo & (wa == `OVSC_TARGET_OFF);
  wire wr_clr   = wlo & (wa == `OVSC_IRQ_STAT_OFF);
  wire wr_mask  = wlo & (wa == `OVSC_IRQ_MASK_OFF);
  wire wr_hit   = (wa == `OVSC_CTRL_OFF) | (wa == `OVSC_TARGET_OFF)
                | (wa == `OVSC_STATE_OFF) | (wa == `OVSC_IRQ_STAT_OFF)
                | (wa == `OVSC_IRQ_MASK_OFF);
  wire rd_hit   = (ra == `OVSC_CTRL_OFF) | (ra == `OVSC_TARGET_OFF)
                | (ra == `OVSC_STATE_OFF) | (ra == `OVSC_IRQ_STAT_OFF)
                | (ra == `OVSC_IRQ_MASK_OFF);
  wire [31:0] state_word = {16'h0000, ref_q, 2'b00, en_seen, dir_down,
                            soft_shutdown_on, slew_discharge_on, state};
  wire [31:0] rd_word =
      (ra == `OVSC_CTRL_OFF)     ? {28'h0000000, ctrl}   :
      (ra == `OVSC_TARGET_OFF)   ? {24'h000000, target}  :
      (ra == `OVSC_STATE_OFF)    ? state_word            :
      (ra == `OVSC_IRQ_STAT_OFF) ? {29'h0, irq_status} :
      (ra == `OVSC_IRQ_MASK_OFF) ? {29'h0, irq_mask}   : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      arready <= 1'b0;
      rvalid  <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= ~next_aw_held;
      wready  <= ~next_w_held;
      bvalid  <= next_bvalid;
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bresp     <= `OVSC_RESP_OKAY;
      rresp     <= `OVSC_RESP_OKAY;
      rdata     <= 32'h00000000;
    end else begin
      if (aw_take) aw_addr_q <= awaddr;
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_do) bresp <= wr_hit ? `OVSC_RESP_OKAY : `OVSC_RESP_SLVERR;
      if (ar_take) begin
        rdata <= rd_word;
        rresp <= rd_hit ? `OVSC_RESP_OKAY : `OVSC_RESP_SLVERR;
      end
    end
  end

  // Set wins over a write-one-clear in the same cycle
  wire [2:0] clr_bits = wr_clr ? w_data_q[2:0] : 3'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl       <= `OVSC_CTRL_RST;
      target     <= `OVSC_TARGET_RST;
      irq_status <= `OVSC_IRQ_RST;
      irq_mask   <= `OVSC_IRQ_RST;
      irq        <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= w_data_q[3:0];
      if (wr_targ) target <= w_data_q[7:0];
      if (wr_mask) irq_mask <= w_data_q[2:0];
      irq_status <= (irq_status & ~clr_bits) | events;
      irq        <= |(((irq_status & ~clr_bits) | events) & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Reference slew and blanking
  // ---------------------------------------------------------------
  ovsc_state_type next_state;
  logic [SW-1:0]  step_cnt;
  logic [TW-1:0]  to_cnt;
  logic [CW-1:0]  cyc_cnt;

  wire [7:0] goal       = target;
  wire switching_on     = ctrl.switch_enable & enable_pin;
  wire at_goal          = (ref_q == goal);
  wire step_due         = (step_cnt == SW'(STEP_CYC - 1));
  wire cycles_done      = switch_cycle & (cyc_cnt == CW'(SETTLE_CYC - 1));
  wire timed_out        = (to_cnt == TW'(TIMEOUT_CYC - 1));
  wire skip_on          = ^ctrl.skip_mode_select;                // [R15]
  wire skip_ultra       = (ctrl.skip_mode_select == 2'b10);      // [R15]

  always_comb begin
    next_state = state;
    events     = 3'h0;
    case (state)
      st_idle: begin
        if (switching_on & ~at_goal) next_state = st_slew;       // [R1]
      end
      st_slew: begin
        if (!switching_on) begin
          next_state = st_idle;
        end else if (at_goal) begin
          next_state       = st_settle;
          events.slew_done = 1'b1;
        end
      end
      st_settle: begin
        if (!switching_on) begin
          next_state = st_idle;
        end else if (!at_goal) begin
          next_state = st_slew;                                  // [R16]
        end else if (cycles_done) begin
          next_state       = st_idle;                            // [R3]
          events.blank_end = 1'b1;
        end else if (timed_out) begin
          next_state     = st_idle;                              // [R6]
          events.timeout = 1'b1;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= st_idle;
      ref_q    <= `OVSC_TARGET_RST;
      step_cnt <= '0;
      dir_down <= 1'b0;
    end else begin
      state <= next_state;
      if (!switching_on) begin
        ref_q    <= goal;
        step_cnt <= '0;
      end else if (state != st_slew || at_goal || step_due) begin
        step_cnt <= '0;
      end else begin
        step_cnt <= step_cnt + SW'(1);
      end
      // A mid-slew retarget keeps the running step count, so its next step can come early
      if (switching_on && state == st_slew && !at_goal && step_due) begin
        ref_q <= (ref_q > goal) ? ref_q - 8'h01 : ref_q + 8'h01;  // [R1] [R16]
      end
      dir_down <= (ref_q > goal);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_cnt  <= '0;
      cyc_cnt <= '0;
    end else if (state != st_settle) begin
      to_cnt  <= '0;
      cyc_cnt <= '0;
    end else begin
      if (!timed_out) to_cnt <= to_cnt + TW'(1);
      if (switch_cycle && !cycles_done) cyc_cnt <= cyc_cnt + CW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Power stage controls
  // ---------------------------------------------------------------
  wire blanking   = (next_state != st_idle);
  // Discharge only on the way down, and only until arrival
  wire next_dis   = ctrl.slew_discharge_enable & switching_on
                  & (next_state == st_slew) & (ref_q > goal);  // [R7] [R8] [R9]
  wire next_strong = gate_request & (high_side_strong | switch_node_high);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_seen              <= 1'b0;
      reference_code       <= `OVSC_TARGET_RST;
      fault_report         <= 1'b0;
      light_load_save      <= 1'b0;
      ultrasonic_save      <= 1'b0;
      slew_discharge_on    <= 1'b0;
      soft_shutdown_on     <= 1'b0;
      high_side_gate_drive <= 1'b0;
      high_side_strong     <= 1'b0;
    end else begin
      // Reset stands for power-up: only a later high arms shutdown
      if (enable_pin) en_seen <= 1'b1;                           // [R13]
      reference_code    <= ref_q;
      fault_report      <= fault_raw & ~blanking;                // [R2]
      light_load_save   <= blanking | skip_on;                   // [R4] [R5]
      ultrasonic_save   <= ~blanking & skip_ultra;               // [R5]
      slew_discharge_on <= next_dis;
      // Latch on en_seen keeps the pull-down after enable drops
      soft_shutdown_on  <= (en_seen | enable_pin) & ~switching_on; // [R11] [R12]
      high_side_gate_drive <= gate_request;
      high_side_strong     <= next_strong;                       // [R14]
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_step_spacing: assert property ( // [R1]
    $past(switching_on) && switching_on && $past(state == st_slew)
    && $changed(ref_q) |-> $past(step_due))
    else $error("reference stepped before its interval");
  a_fault_blank: assert property ( // [R2]
    (state != st_idle) |-> !fault_report)
    else $error("fault reported during blanking");
  a_settle_cycles: assert property ( // [R3]
    state == st_settle && switching_on && at_goal && cycles_done
    |=> state == st_idle && fault_report == $past(fault_raw))
    else $error("blanking did not end after eight cycles");
  a_dcm_forced: assert property ( // [R4]
    (state == st_slew) |-> light_load_save && !ultrasonic_save)
    else $error("discontinuous mode not forced while slewing");
  // Reset in the antecedent: the first edge out of reset still shows 0
  a_mode_back: assert property ( // [R5] [R15]
    aresetn && state == st_idle && next_state == st_idle
    |=> light_load_save == $past(skip_on))
    else $error("conduction mode not restored after blanking");
  a_timeout_end: assert property ( // [R6]
    state == st_settle && switching_on && at_goal && timed_out
    |=> state == st_idle)
    else $error("timeout did not end blanking");
  a_discharge_down: assert property ( // [R7] [R8] [R9]
    slew_discharge_on |-> state == st_slew && dir_down
    && $past(ctrl.slew_discharge_enable))
    else $error("discharge load on outside a downward slew");
  a_shutdown_arm: assert property ( // [R11] [R13]
    $past(!en_seen) && $past(!enable_pin) |-> !soft_shutdown_on)
    else $error("soft shutdown engaged without enable seen");
  a_shutdown_hold: assert property ( // [R12]
    soft_shutdown_on && !enable_pin |=> soft_shutdown_on)
    else $error("soft shutdown released when enable dropped");
  a_strong_late: assert property ( // [R14]
    $rose(high_side_strong) |-> $past(switch_node_high)
    && $past(gate_request))
    else $error("strong drive before switch node rise");

  c_slew_done: cover property (events.slew_done);
  c_blank_end: cover property (events.blank_end);
  c_timeout:   cover property (events.timeout);
  c_retarget:  cover property (state == st_settle ##1 state == st_slew);
endmodule : ovsc_top
`default_nettype wire

// ---- include/ovsc_regs.svh ----
// How it works
// R1: Reference steps one code toward a new trim or margin target every 32 us.
// R2: Fault reporting is masked from slew start until blanking ends.
// R3: After arrival, blanking ends once eight switching cycles are counted.
// R4: Light-load (discontinuous) operation is forced for the whole slew and blank.
// R5: At blank end the selected skip mode drives conduction mode again.
// R6: Without enough cycles, blanking ends anyway after a 1 ms timeout.
// R7: With discharge enabled, the 10 ohm load is on while slewing down.
// R8: The discharge load stays off for upward slews.
// R9: Discharge load releases as soon as the reference reaches its target.
// R10: Software should leave skip mode off or ultrasonic before big downward slews.
// R11: Switching disabled turns on the 10 ohm soft-shutdown pull-down.
// R12: Soft-shutdown stays on after the enable pin later goes low.
// R13: Soft-shutdown never engages unless enable was seen high since reset.
// R14: High-side gate starts weak, goes strong once switch node passes 0.5 V.
// R15: Skip codes 01 and 10 enable power save, 10 ultrasonic, else continuous.
// R16: A retarget mid-slew continues from the present reference and re-blanks.
`ifndef OVSC_REGS_SVH
`define OVSC_REGS_SVH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define OVSC_CTRL_OFF     8'h00
`define OVSC_TARGET_OFF   8'h04
`define OVSC_STATE_OFF    8'h08
`define OVSC_IRQ_STAT_OFF 8'h0c
`define OVSC_IRQ_MASK_OFF 8'h10
`define OVSC_CTRL_RST     4'h9
`define OVSC_TARGET_RST   8'h6f
`define OVSC_IRQ_RST      3'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define OVSC_CLK_MHZ      100
`define OVSC_STEP_US      32
`define OVSC_TIMEOUT_US   1000
`define OVSC_STEP_CYC     (`OVSC_STEP_US * `OVSC_CLK_MHZ)
`define OVSC_TIMEOUT_CYC  (`OVSC_TIMEOUT_US * `OVSC_CLK_MHZ)
`define OVSC_SETTLE_CYC   8
`define OVSC_RESP_OKAY    2'h0
`define OVSC_RESP_SLVERR  2'h2

`endif

// ---- include/ovsc_pkg.sv ----
`default_nettype none
package ovsc_pkg;
  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_slew   = 2'b01,
    st_settle = 2'b11
  } ovsc_state_type;

  typedef struct packed {
    logic [1:0] skip_mode_select;
    logic       slew_discharge_enable;
    logic       switch_enable;
  } ovsc_ctrl_type;

  typedef struct packed {
    logic [2:0] margin;
    logic [4:0] feedback_trim_setting;
  } ovsc_target_type;

  // Event bit order in the interrupt registers
  typedef struct packed {
    logic timeout;
    logic blank_end;
    logic slew_done;
  } ovsc_event_type;
endpackage : ovsc_pkg
`default_nettype wire

// ---- sim/ovsc_plant_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Power stage stand-in: PWM, switch node and cycle pulses
// ------------------------------------------------------------
module ovsc_plant_model #(
  parameter int PERIOD = 6
) (
  input  wire logic aclk,
  input  wire logic run,
  input  wire logic high_side_gate_drive,
  output var  logic gate_request,
  output var  logic switch_cycle,
  output var  logic switch_node_high
);
  logic [3:0] phase;

  initial begin
    {phase, gate_request, switch_cycle, switch_node_high} = '0;
  end

  // With run low the load is too light for any cycle to happen
  always @(posedge aclk) begin
    phase        <= (!run || phase == 4'(PERIOD - 1)) ? 4'h0 : phase + 4'h1;
    gate_request <= run && phase < 4'h4;
    switch_cycle <= run && phase == 4'h0;
    // Node lags the gate by a cycle while the diode recovers
    switch_node_high <= high_side_gate_drive;
  end
endmodule : ovsc_plant_model
`default_nettype wire

// ---- sim/ovsc_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ovsc_regs.svh"
module ovsc_tb_top;
  import ovsc_pkg::*;
  localparam int STEP = 4;
  localparam int TMO  = 80;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, run, irq;
  logic [7:0]  awaddr, araddr, reference_code, v;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        enable_pin, switch_cycle, fault_raw, gate_request;
  logic        switch_node_high, fault_report, light_load_save;
  logic        ultrasonic_save, slew_discharge_on, soft_shutdown_on;
  logic        high_side_gate_drive, high_side_strong;
  int          mismatches = 0;
  int          n_compared = 0;
  int          n;

  ovsc_top #(.STEP_CYC(STEP), .TIMEOUT_CYC(TMO), .SETTLE_CYC(8)) u_ovsc_top (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .enable_pin, .switch_cycle, .fault_raw,
    .gate_request, .switch_node_high, .reference_code, .fault_report,
    .light_load_save, .ultrasonic_save, .slew_discharge_on,
    .soft_shutdown_on, .high_side_gate_drive, .high_side_strong, .irq);
  ovsc_plant_model u_ovsc_plant_model (.aclk, .run, .high_side_gate_drive,
    .gate_request, .switch_cycle, .switch_node_high);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_of_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  function logic [31:0] ctrl(input logic [1:0] s, input logic d, input logic e);
    ovsc_ctrl_type c;
    c = '{s, d, e};
    return {28'h0, c};
  endfunction : ctrl

  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick

  // Address and data go up together; each drops when its own ready is seen
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ap, wp;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && awready === 1'b1) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wp && wready === 1'b1) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check(32'(rresp), 32'(er));
  endtask : rd

  task do_reset;
    aresetn <= 1'b0;
    tick(4);
    aresetn <= 1'b1;
    tick(1);
  endtask : do_reset

  task wait_ref(input logic [7:0] t);
    while (reference_code !== t) @(posedge aclk);
  endtask : wait_ref

  task step_gap(output int k);
    logic [7:0] b;
    b = reference_code;
    k = 0;
    while (reference_code === b) begin
      @(posedge aclk);
      k++;
    end
  endtask : step_gap

  task pulses(input int k);
    int c;
    c = 0;
    while (c < k) begin
      @(posedge aclk);
      if (switch_cycle === 1'b1) c++;
    end
  endtask : pulses

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_of_test();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {enable_pin, fault_raw, run, awaddr, araddr, wdata, wstrb} = '0;
    do_reset();
    check(32'(soft_shutdown_on), 32'h0);
    rd(`OVSC_CTRL_OFF, 32'(`OVSC_CTRL_RST), `OVSC_RESP_OKAY);
    rd(`OVSC_TARGET_OFF, 32'(`OVSC_TARGET_RST), `OVSC_RESP_OKAY);
    rd(`OVSC_IRQ_MASK_OFF, 32'h0, `OVSC_RESP_OKAY);
    rd(8'h14, 32'h0, `OVSC_RESP_SLVERR);
    wr(8'h14, 32'h1, `OVSC_RESP_SLVERR);
    // Skip mode off ahead of the downward slew
    wr(`OVSC_CTRL_OFF, ctrl(2'b00, 1'b1, 1'b1), `OVSC_RESP_OKAY);
    enable_pin <= 1'b1;
    fault_raw  <= 1'b1;
    tick(4);
    wr(`OVSC_TARGET_OFF, 32'h72, `OVSC_RESP_OKAY);
    tick(2);
    check(32'(light_load_save), 32'h1);
    check(32'(fault_report), 32'h0);
    check(32'(slew_discharge_on), 32'h0);
    step_gap(n);
    step_gap(n);
    check(32'(n), 32'(STEP));
    wait_ref(8'h72);
    run <= 1'b1;
    pulses(7);
    tick(3);
    check(32'(light_load_save), 32'h1);
    check(32'(fault_report), 32'h0);
    pulses(1);
    tick(3);
    check(32'(light_load_save), 32'h0);
    check(32'(fault_report), 32'h1);
    // Wait for a fresh pulse so its weak phase is seen
    while (high_side_gate_drive !== 1'b0) @(posedge aclk);
    while (high_side_gate_drive !== 1'b1) @(posedge aclk);
    check(32'(high_side_strong), 32'h0);
    while (switch_node_high !== 1'b1) @(posedge aclk);
    tick(2);
    check(32'(high_side_strong), 32'h1);
    v[0] = gate_request;
    tick(1);
    check(32'(high_side_gate_drive), 32'(v[0]));
    rd(`OVSC_IRQ_STAT_OFF, 32'h3, `OVSC_RESP_OKAY);
    check(32'(irq), 32'h0);
    wr(`OVSC_IRQ_MASK_OFF, 32'h7, `OVSC_RESP_OKAY);
    tick(2);
    check(32'(irq), 32'h1);
    wr(`OVSC_IRQ_STAT_OFF, 32'h3, `OVSC_RESP_OKAY);
    tick(2);
    check(32'(irq), 32'h0);
    run <= 1'b0;
    wr(`OVSC_TARGET_OFF, 32'h6e, `OVSC_RESP_OKAY);
    tick(2);
    check(32'(slew_discharge_on), 32'h1);
    wait_ref(8'h6e);
    tick(3);
    check(32'(slew_discharge_on), 32'h0);
    tick(TMO - 10);
    check(32'(light_load_save), 32'h1);
    tick(16);
    check(32'(light_load_save), 32'h0);
    rd(`OVSC_IRQ_STAT_OFF, 32'h5, `OVSC_RESP_OKAY);
    wr(`OVSC_IRQ_STAT_OFF, 32'h7, `OVSC_RESP_OKAY);
    // Turn round in mid-slew: next step goes down from where it stands
    wr(`OVSC_TARGET_OFF, 32'h7a, `OVSC_RESP_OKAY);
    step_gap(n);
    step_gap(n);
    wr(`OVSC_TARGET_OFF, 32'h6f, `OVSC_RESP_OKAY);
    v = reference_code;
    step_gap(n);
    check(32'(reference_code), 32'(v - 8'h1));
    wait_ref(8'h6f);
    run <= 1'b1;
    pulses(9);
    for (int c = 0; c < 4; c++) begin
      wr(`OVSC_CTRL_OFF, ctrl(c[1:0], 1'b0, 1'b1), `OVSC_RESP_OKAY);
      tick(3);
      check(32'(light_load_save), 32'(c == 1 || c == 2));
      check(32'(ultrasonic_save), 32'(c == 2));
    end
    wr(`OVSC_CTRL_OFF, ctrl(2'b00, 1'b0, 1'b0), `OVSC_RESP_OKAY);
    tick(2);
    check(32'(soft_shutdown_on), 32'h1);
    enable_pin <= 1'b0;
    tick(3);
    check(32'(soft_shutdown_on), 32'h1);
    do_reset();
    tick(3);
    check(32'(soft_shutdown_on), 32'h0);
    rd(`OVSC_STATE_OFF, {16'h0000, 8'(`OVSC_TARGET_RST), 8'h00},
       `OVSC_RESP_OKAY);
    end_of_test();
  end
endmodule : ovsc_tb_top
`default_nettype wire
